//--- include/rpc_regs.svh
// timing counts, frame limits and link codes for the reader poll controller
// assumes the system clock rate given by RPC_CLK_MHZ
`ifndef RPC_REGS_SVH
`define RPC_REGS_SVH

`define RPC_CLK_MHZ      100
`define RPC_LEADIN_US    10000
`define RPC_DEADLINE_US  150000
`define RPC_FIELDOFF_US  500
`define RPC_ANSWAIT_US   1000
`define RPC_LEADIN_CYC   (`RPC_LEADIN_US * `RPC_CLK_MHZ)
`define RPC_DEADLINE_CYC (`RPC_DEADLINE_US * `RPC_CLK_MHZ)
`define RPC_FIELDOFF_CYC (`RPC_FIELDOFF_US * `RPC_CLK_MHZ)
`define RPC_ANSWAIT_CYC  (`RPC_ANSWAIT_US * `RPC_CLK_MHZ)

`define RPC_FRAME_256    13'h0100
`define RPC_FRAME_1K     13'h0400
`define RPC_FRAME_2K     13'h0800
`define RPC_FRAME_4K     13'h1000
`define RPC_ERR_LIMIT    4'h3
`define RPC_NAK_TRIES    2'h2

// link codes, values arbitrary
`define RPC_CODE_POLLA   8'h5A
`define RPC_CODE_POLLB   8'hA5
`define RPC_CODE_FEND    8'h3C
`define RPC_CODE_NAK     8'hC3

`endif

//--- include/rpc_pkg.sv
// types shared by the reader poll controller
// assumes nothing beyond a SystemVerilog tool
package rpc_pkg;
	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_OFF    = 8'h02,
		ST_LEADIN = 8'h04,
		ST_POLL   = 8'h08,
		ST_PWAIT  = 8'h10,
		ST_SEND   = 8'h20,
		ST_FWAIT  = 8'h40,
		ST_NAK    = 8'h80
	} rpc_state_t;
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0, CMD_POLLA = 3'h1, CMD_POLLB = 3'h2,
		CMD_DATA = 3'h3, CMD_FEND = 3'h4, CMD_NAK = 3'h5
	} rpc_cmd_kind_t;
	// r10170 is reader-to-chip only
	typedef enum logic [2:0] {
		R106 = 3'h0, R212 = 3'h1, R424 = 3'h2, R848 = 3'h3,
		R1695 = 3'h4, R3390 = 3'h5, R6780 = 3'h6, R10170 = 3'h7
	} rpc_rate_t;
	typedef struct packed {
		rpc_cmd_kind_t kind;
		logic [7:0]    data;
	} rpc_cmd_t;
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} rpc_byte_t;
	typedef struct packed {
		logic err;
		logic blockCap;
	} rpc_ans_t;
endpackage : rpc_pkg

//--- logic/rpc_reader.sv
// reader-side poll controller: field lead-in, A/B polling, framing, NAK recovery
// assumes a link front end clocked by linkClk and answer pins from the chip
// What this block does
// - hold unmodulated carrier 10 ms before any poll request
// - alternate type A and type B polls equally often
// - fixed readers reset the field between same-type polls, except when a lost card restarts polling
// - flag when either poll type is older than 150 ms
// - other modulation polls allowed only if timing stays met; none here
// - 106 and 424 kbit/s always available on the link
// - optional rates 212 up to 10.17 Mbit/s may be selected
// - frames up to 4 kbytes, at least 1 kbyte offered
// - frames above 1 kbyte use the error-correcting format
// - split payload into full frames, only the last one short
// - on error or silence send a negative acknowledge block, at most twice before the card is dropped
// - many errors at optional settings lower rate and frame size
// - handheld readers cap frames at 256 bytes
// - dismiss cards without block transport support
// - chip load disturbance tolerance is not implemented
`timescale 1ns/1ps
`include "rpc_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module rpc_fifo
	import rpc_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic             wrValid,
	output logic                  wrReady,
	output logic      [WIDTH-1:0] rdData,
	output logic                  rdValid,
	input  wire logic             rdReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
	logic [AW:0]      count, next_count;
	logic             push, pop, next_wrReady;

	// pointers wrap at depth; ready is registered so the source sees a clean level
	always_comb begin
		push = wrValid && wrReady;
		pop = rdValid && rdReady;
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		if (push) begin
			next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : AW'(wrPtr + 1'b1);
		end
		if (pop) begin
			next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : AW'(rdPtr + 1'b1);
		end
		next_count = (AW + 1)'(count + {AW'(0), push} - {AW'(0), pop});
		next_wrReady = (next_count < (AW + 1)'(DEPTH));
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			wrReady <= 1'b0;
		end else begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			wrReady <= next_wrReady;
		end
	end

	// storage has no reset; only valid entries are ever read
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr] <= wrData;
		end
	end

	assign rdData = mem[rdPtr];
	assign rdValid = (count != '0);
endmodule : rpc_fifo

////////////////////////////////////////////////////////////////////////////////
module rpc_reader
	import rpc_pkg::*;
#(
	parameter int LEADIN_CYC   = `RPC_LEADIN_CYC,
	parameter int DEADLINE_CYC = `RPC_DEADLINE_CYC,
	parameter int FIELDOFF_CYC = `RPC_FIELDOFF_CYC,
	parameter int ANSWAIT_CYC  = `RPC_ANSWAIT_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       linkClk,
	input  wire logic       pollEnable,
	input  wire logic       fixedReader,
	input  wire logic       handheld,
	input  wire rpc_rate_t  rateWant,
	input  wire logic [1:0] frameSel,
	input  wire rpc_byte_t  inByte,
	input  wire logic       inValid,
	output logic            inReady,
	input  wire logic       chipAnswer,
	input  wire logic       chipError,
	input  wire logic       chipBlockCap,
	output logic            fieldOn,
	output logic            txBit,
	output logic            txActive,
	output rpc_cmd_kind_t   txKind,
	output rpc_rate_t       linkRate,
	output rpc_rate_t       curRate,
	output logic [12:0]     frameMax,
	output logic            useEcc,
	output logic            cardFound,
	output logic            deadlineMiss,
	output logic [3:0]      errCnt
);
	// frame size choice; handheld readers never go past 256 bytes
	function automatic logic [12:0] frameBytes(input logic [1:0] sel, input logic hh);
		logic [12:0] b;
		b = `RPC_FRAME_256;
		case (sel)
			2'h1: b = `RPC_FRAME_1K;
			2'h2: b = `RPC_FRAME_2K;
			2'h3: b = `RPC_FRAME_4K;
			default: b = `RPC_FRAME_256;
		endcase
		return hh ? `RPC_FRAME_256 : b;
	endfunction : frameBytes

	rpc_state_t  state, next_state;
	logic [23:0] cnt, next_cnt, sinceA, sinceB, next_sinceA, next_sinceB;
	logic [12:0] frmCnt, next_frmCnt, next_frameMax;
	logic [3:0]  next_errCnt;
	logic [1:0]  nakTries, next_nakTries;
	logic        pollNextB, next_pollNextB, pendEnd, next_pendEnd, hhL, next_hhL;
	logic        next_fieldOn, next_cardFound, next_deadlineMiss, next_useEcc;
	rpc_rate_t   next_curRate;
	rpc_cmd_t    cmdReg, next_cmdReg;
	logic        cmdTgl, next_cmdTgl, ackS1, ackS2, ansS1, ansS2, ansS3, ackTgl, ansTgl;
	logic        cmdBusy, ansEvt, issue, fifoPop, polling;
	rpc_byte_t   fifoData;
	logic        fifoValid;
	rpc_ans_t    ansStat;

	rpc_fifo #(.WIDTH(9), .DEPTH(4)) payloadFifo (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.wrData  (inByte),
		.wrValid (inValid),
		.wrReady (inReady),
		.rdData  (fifoData),
		.rdValid (fifoValid),
		.rdReady (fifoPop)
	);

	// handshake back from the link: busy until the ack toggle matches
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			{ackS1, ackS2, ansS1, ansS2, ansS3} <= 5'h00;
		end else begin
			{ackS1, ackS2} <= {ackTgl, ackS1};
			{ansS1, ansS2, ansS3} <= {ansTgl, ansS1, ansS2};
		end
	end
	assign cmdBusy = (cmdTgl != ackS2);
	assign ansEvt = (ansS2 != ansS3);
	assign polling = (state == ST_LEADIN) || (state == ST_POLL) || (state == ST_PWAIT)
		|| (state == ST_OFF);

	////////////////////////////////////////////////////////////////////////////
	// main sequencer: field, polls, frames and recovery
	always_comb begin
		next_state = state;
		next_cnt = (cnt == 24'hFF_FFFF) ? cnt : 24'(cnt + 1'b1);
		next_frmCnt = frmCnt;
		next_frameMax = frameMax;
		next_errCnt = errCnt;
		next_nakTries = nakTries;
		next_pollNextB = pollNextB;
		next_pendEnd = pendEnd;
		next_hhL = hhL;
		next_fieldOn = fieldOn;
		next_cardFound = cardFound;
		next_curRate = curRate;
		next_cmdReg = cmdReg;
		next_cmdTgl = cmdTgl;
		issue = 1'b0;
		fifoPop = 1'b0;
		// poll ages count only while hunting for a card
		next_sinceA = polling ? ((sinceA == 24'hFF_FFFF) ? sinceA : 24'(sinceA + 1'b1)) : '0;
		next_sinceB = polling ? ((sinceB == 24'hFF_FFFF) ? sinceB : 24'(sinceB + 1'b1)) : '0;
		case (state)
			ST_IDLE: begin
				next_fieldOn = 1'b0;
				if (pollEnable) begin
					next_state = ST_LEADIN;
					next_fieldOn = 1'b1;
					next_cnt = '0;
					next_pollNextB = 1'b0;
					next_curRate = rateWant;
					next_hhL = handheld;
					next_frameMax = frameBytes(frameSel, handheld);
					next_errCnt = '0;
				end
			end
			ST_OFF: begin
				if (cnt >= 24'(FIELDOFF_CYC - 1)) begin
					next_state = ST_LEADIN;
					next_fieldOn = 1'b1;
					next_cnt = '0;
				end
			end
			ST_LEADIN: begin
				if (cnt >= 24'(LEADIN_CYC - 1)) begin
					next_state = ST_POLL;
				end
			end
			ST_POLL: begin
				// only type A and B are polled, no other modulation
				if (!cmdBusy) begin
					issue = 1'b1;
					next_cmdReg.kind = pollNextB ? CMD_POLLB : CMD_POLLA;
					next_cmdReg.data = pollNextB ? `RPC_CODE_POLLB : `RPC_CODE_POLLA;
					next_cmdTgl = ~cmdTgl;
					if (pollNextB) begin
						next_sinceB = '0;
					end else begin
						next_sinceA = '0;
					end
					next_state = ST_PWAIT;
					next_cnt = '0;
				end
			end
			ST_PWAIT: begin
				if ((ansEvt && !ansStat.err && ansStat.blockCap)) begin
					next_state = ST_SEND;
					next_cardFound = 1'b1;
					next_frmCnt = '0;
					next_nakTries = '0;
				end else if (ansEvt || cnt >= 24'(ANSWAIT_CYC - 1)) begin
					// cards without block transport are dismissed like silence
					next_pollNextB = ~pollNextB;
					next_cnt = '0;
					if (pollNextB && fixedReader) begin
						next_state = ST_OFF;
						next_fieldOn = 1'b0;
					end else begin
						next_state = ST_POLL;
					end
				end
			end
			ST_SEND: begin
				if (!cmdBusy && pendEnd) begin
					issue = 1'b1;
					next_cmdReg = '{kind: CMD_FEND, data: `RPC_CODE_FEND};
					next_cmdTgl = ~cmdTgl;
					next_pendEnd = 1'b0;
					next_state = ST_FWAIT;
					next_cnt = '0;
				end else if (!cmdBusy && fifoValid) begin
					issue = 1'b1;
					fifoPop = 1'b1;
					next_cmdReg = '{kind: CMD_DATA, data: fifoData.data};
					next_cmdTgl = ~cmdTgl;
					next_frmCnt = 13'(frmCnt + 1'b1);
					// a frame closes only when full or at the payload end
					if (fifoData.last || 13'(frmCnt + 1'b1) == frameMax) begin
						next_pendEnd = 1'b1;
					end
				end
			end
			ST_FWAIT: begin
				if (ansEvt && !ansStat.err) begin
					next_state = ST_SEND;
					next_frmCnt = '0;
					next_nakTries = '0;
				end else if (ansEvt || cnt >= 24'(ANSWAIT_CYC - 1)) begin
					if (nakTries == `RPC_NAK_TRIES) begin
						next_state = ST_IDLE; // card lost
						next_cardFound = 1'b0;
					end else begin
						next_state = ST_NAK;
					end
				end
			end
			ST_NAK: begin
				if (!cmdBusy) begin
					issue = 1'b1;
					next_cmdReg = '{kind: CMD_NAK, data: `RPC_CODE_NAK};
					next_cmdTgl = ~cmdTgl;
					next_nakTries = 2'(nakTries + 1'b1);
					next_errCnt = (errCnt == 4'hF) ? errCnt : 4'(errCnt + 1'b1);
					next_state = ST_FWAIT;
					next_cnt = '0;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// heavy errors at optional settings fall back to the safest link
		if (errCnt >= `RPC_ERR_LIMIT && (!(curRate inside {R106, R424})
			|| frameMax > `RPC_FRAME_256)) begin
			next_curRate = R106;
			next_frameMax = `RPC_FRAME_256;
			next_errCnt = '0;
		end
		if (!pollEnable && state != ST_IDLE) begin
			next_state = ST_IDLE;
			next_fieldOn = 1'b0;
			next_cardFound = 1'b0;
			next_pendEnd = 1'b0;
		end
		next_deadlineMiss = (next_sinceA >= 24'(DEADLINE_CYC - 1))
			|| (next_sinceB >= 24'(DEADLINE_CYC - 1));
		next_useEcc = (next_frameMax > `RPC_FRAME_1K);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			cnt <= '0;
			sinceA <= '0;
			sinceB <= '0;
			frmCnt <= '0;
			frameMax <= `RPC_FRAME_256;
			errCnt <= '0;
			nakTries <= '0;
			pollNextB <= 1'b0;
			pendEnd <= 1'b0;
			hhL <= 1'b0;
			fieldOn <= 1'b0;
			cardFound <= 1'b0;
			curRate <= R106;
			cmdReg <= '{kind: CMD_NONE, data: 8'h00};
			cmdTgl <= 1'b0;
			deadlineMiss <= 1'b0;
			useEcc <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			sinceA <= next_sinceA;
			sinceB <= next_sinceB;
			frmCnt <= next_frmCnt;
			frameMax <= next_frameMax;
			errCnt <= next_errCnt;
			nakTries <= next_nakTries;
			pollNextB <= next_pollNextB;
			pendEnd <= next_pendEnd;
			hhL <= next_hhL;
			fieldOn <= next_fieldOn;
			cardFound <= next_cardFound;
			curRate <= next_curRate;
			cmdReg <= next_cmdReg;
			cmdTgl <= next_cmdTgl;
			deadlineMiss <= next_deadlineMiss;
			useEcc <= next_useEcc;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link domain: command shifter and answer capture on linkClk
	logic          cmdS1, cmdS2, cmdS3, next_ackTgl, next_ansTgl;
	logic          ansP1, ansP2, ansP3, errP1, errP2, blkP1, blkP2;
	logic [7:0]    shift, next_shift;
	logic [3:0]    bitCnt, next_bitCnt;
	logic          next_txBit, next_txActive;
	rpc_cmd_kind_t next_txKind;
	rpc_ans_t      next_ansStat;
	rpc_rate_t     rateS1, rateS2, rateS3;

	// pins and sys-side levels pass two flops; linkRate follows curRate whenever it settles, even in the middle of a byte
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			{cmdS1, cmdS2, cmdS3} <= 3'h0;
			{ansP1, ansP2, ansP3, errP1, errP2, blkP1, blkP2} <= 7'h00;
			rateS1 <= R106;
			rateS2 <= R106;
			rateS3 <= R106;
			linkRate <= R106;
		end else begin
			{cmdS1, cmdS2, cmdS3} <= {cmdTgl, cmdS1, cmdS2};
			{ansP1, ansP2, ansP3} <= {chipAnswer, ansP1, ansP2};
			{errP1, errP2, blkP1, blkP2} <= {chipError, errP1, chipBlockCap, blkP1};
			rateS1 <= curRate;
			rateS2 <= rateS1;
			rateS3 <= rateS2;
			// a multi-bit word: taken only once two synced samples agree
			linkRate <= (rateS2 == rateS3) ? rateS3 : linkRate;
		end
	end

	// cmdReg is held by the sys side until ackTgl returns, so it is stable here
	always_comb begin
		next_shift = shift;
		next_bitCnt = bitCnt;
		next_txBit = txBit;
		next_txActive = txActive;
		next_txKind = txKind;
		next_ackTgl = ackTgl;
		next_ansTgl = ansTgl;
		next_ansStat = ansStat;
		if (txActive) begin
			next_txBit = shift[7];
			next_shift = {shift[6:0], 1'b0};
			next_bitCnt = 4'(bitCnt - 1'b1);
			if (bitCnt == 4'h1) begin
				next_txActive = 1'b0;
				next_ackTgl = cmdS3;
			end
		end else if (cmdS2 != cmdS3 && cmdS3 != ackTgl) begin
			next_txActive = 1'b1;
			next_txKind = cmdReg.kind;
			next_shift = cmdReg.data;
			next_bitCnt = 4'h8;
		end else if (cmdS2 != ackTgl && cmdS2 == cmdS3) begin
			next_txActive = 1'b1;
			next_txKind = cmdReg.kind;
			next_shift = cmdReg.data;
			next_bitCnt = 4'h8;
		end
		// no chip load disturbance filtering: every rising answer edge counts
		if (ansP2 && !ansP3) begin
			next_ansStat = '{err: errP2, blockCap: blkP2};
			next_ansTgl = ~ansTgl;
		end
	end

	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			shift <= 8'h00;
			bitCnt <= 4'h0;
			txBit <= 1'b0;
			txActive <= 1'b0;
			txKind <= CMD_NONE;
			ackTgl <= 1'b0;
			ansTgl <= 1'b0;
			ansStat <= '{err: 1'b0, blockCap: 1'b0};
		end else begin
			shift <= next_shift;
			bitCnt <= next_bitCnt;
			txBit <= next_txBit;
			txActive <= next_txActive;
			txKind <= next_txKind;
			ackTgl <= next_ackTgl;
			ansTgl <= next_ansTgl;
			ansStat <= next_ansStat;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checking helpers: field-on age, poll history, field resets seen
	logic [23:0] onAge;
	logic        lastB, offSeen, aBefore;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			onAge <= '0;
			lastB <= 1'b1;
			offSeen <= 1'b0;
			aBefore <= 1'b0;
		end else begin
			onAge <= !fieldOn ? '0 : (onAge == 24'hFF_FFFF) ? onAge : 24'(onAge + 1'b1);
			// a new session restarts the alternation from type A
			if (state == ST_IDLE) begin
				lastB <= 1'b1;
			end else if (issue && next_cmdReg.kind inside {CMD_POLLA, CMD_POLLB}) begin
				lastB <= (next_cmdReg.kind == CMD_POLLB);
			end
			if (state == ST_OFF) begin
				offSeen <= 1'b1;
			end else if (issue && next_cmdReg.kind == CMD_POLLA) begin
				offSeen <= 1'b0;
			end
			if (issue && next_cmdReg.kind == CMD_POLLA) begin
				aBefore <= 1'b1;
			end
		end
	end

	sequence s_fieldReset;
		state == ST_OFF ##1 state == ST_LEADIN;
	endsequence
	sequence s_badAnswer;
		state == ST_FWAIT && ansEvt && ansStat.err && nakTries != `RPC_NAK_TRIES && pollEnable;
	endsequence

	a_leadin_before_poll: assert property (@(posedge sys_clk) disable iff (!nrst)
		issue && next_cmdReg.kind inside {CMD_POLLA, CMD_POLLB} |-> onAge >= 24'(LEADIN_CYC))
		else $error("poll sent before carrier lead-in elapsed");
	a_poll_alternates: assert property (@(posedge sys_clk) disable iff (!nrst)
		issue && next_cmdReg.kind inside {CMD_POLLA, CMD_POLLB}
		|-> (next_cmdReg.kind == CMD_POLLB) != lastB)
		else $error("two polls of one type in a row");
	a_reset_between: assert property (@(posedge sys_clk) disable iff (!nrst)
		fixedReader && aBefore && issue && next_cmdReg.kind == CMD_POLLA |-> offSeen)
		else $error("fixed reader repeated type without field reset");
	a_deadline_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		polling && sinceA == 24'(DEADLINE_CYC - 2) && !issue |=> deadlineMiss)
		else $error("stale poll not flagged");
	a_handheld_cap: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == ST_SEND && hhL |-> frameMax <= `RPC_FRAME_256)
		else $error("handheld frame above 256 bytes");
	a_ecc_big_frame: assert property (@(posedge sys_clk) disable iff (!nrst)
		state != ST_IDLE && frameMax > `RPC_FRAME_1K |-> useEcc)
		else $error("large frame without error correction");
	a_frame_fill: assert property (@(posedge sys_clk) disable iff (!nrst)
		fifoPop && pollEnable && 13'(frmCnt + 1'b1) == frameMax |=> pendEnd)
		else $error("full frame not closed");
	a_nak_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_badAnswer |=> state == ST_NAK ##[0:100] (issue && next_cmdReg.kind == CMD_NAK))
		else $error("no negative acknowledge after error");
	a_fallback_rate: assert property (@(posedge sys_clk) disable iff (!nrst)
		errCnt >= `RPC_ERR_LIMIT && frameMax > `RPC_FRAME_256
		|=> curRate == R106 && frameMax == `RPC_FRAME_256)
		else $error("no fallback after error burst");
	a_leadin_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_fieldReset |-> cnt == 24'h00_0000 && fieldOn)
		else $error("lead-in not restarted after field reset");
	a_byte_eight_bits: assert property (@(posedge linkClk) disable iff (!nrst)
		$rose(txActive) |-> txActive [*8] ##1 !txActive)
		else $error("link byte not eight bits long");
endmodule : rpc_reader

//--- bench/rpc_chip_model.sv
// behavioural travel_document_chip facing the reader poll controller
// assumes the reader's field, byte kind and byte active pins on linkClk
`timescale 1ns/1ps
module rpc_chip_model
	import rpc_pkg::*;
#(
	parameter int READY_CYC = 120
) (
	input  wire logic          linkClk,
	input  wire logic          fieldOn,
	input  wire logic          txActive,
	input  wire rpc_cmd_kind_t txKind,
	input  wire logic          typeB,
	input  wire logic          errMode,
	input  wire logic          capMode,
	output logic               chipAnswer,
	output logic               chipError,
	output logic               chipBlockCap
);
	int            onCnt;
	int            step;
	logic          wasAct;
	logic          myType;
	rpc_cmd_kind_t k;

	initial begin
		{chipAnswer, chipError, chipBlockCap, wasAct, myType} = 5'h00;
		onCnt = 0;
		step = 0;
	end

	////////////////////////////////////////////////////////////////////////////
	// answers after a matching poll, frame end or NAK byte ends; any link rate is accepted
	always @(posedge linkClk) begin
		wasAct <= txActive;
		onCnt <= fieldOn ? onCnt + 1 : 0;
		if (!fieldOn)
			myType <= typeB; // type changes only while reset
		k = txKind;
		if (wasAct && !txActive) begin
			if (k == (myType ? CMD_POLLB : CMD_POLLA) && onCnt >= READY_CYC)
				step <= 1;
			else if (k == CMD_FEND || k == CMD_NAK)
				step <= 1;
		end else if (step != 0)
			step <= (step == 7) ? 0 : step + 1;
		// flags stand around the pulse, toggle otherwise so stale values never match
		chipError <= (step inside {[1:6]}) ? errMode : ~chipError;
		chipBlockCap <= (step inside {[1:6]}) ? capMode : ~chipBlockCap;
		chipAnswer <= step inside {[3:6]};
	end
endmodule : rpc_chip_model

//--- bench/tb_rpc_reader.sv
// self-checking bench for the reader poll controller and a chip model
// assumes shortened counts, 10 ns sys_clk and a free 15 ns linkClk
`timescale 1ns/1ps
module tb_rpc_reader
	import rpc_pkg::*;
;
	localparam int LEAD = 200;
	logic          sys_clk = 0, linkClk = 0, nrst = 0;
	logic          pollEnable = 0, fixedReader = 0, handheld = 0, inValid = 0;
	logic          typeB = 0, errMode = 0, capMode = 0, wasAct = 0;
	logic [1:0]    frameSel = 2'h0;
	rpc_rate_t     rateWant = R106;
	rpc_byte_t     inByte = 9'h000;
	logic          inReady, chipAnswer, chipError, chipBlockCap, fieldOn, txBit, txActive;
	logic          useEcc, cardFound, deadlineMiss;
	rpc_cmd_kind_t txKind;
	rpc_rate_t     linkRate, curRate;
	logic [12:0]   frameMax;
	logic [3:0]    errCnt;
	rpc_cmd_kind_t kinds[$];
	logic [7:0]    bytes[$];
	logic [7:0]    rxSh = 8'h00;
	int            miscompares = 0, samples_checked = 0, cyc = 0;

	always #5 sys_clk = ~sys_clk;
	initial begin
		#2.3;
		forever #7.5 linkClk = ~linkClk;
	end

	rpc_reader #(.LEADIN_CYC(LEAD), .DEADLINE_CYC(3000), .FIELDOFF_CYC(50),
		.ANSWAIT_CYC(400)) dut (.sys_clk, .nrst, .linkClk, .pollEnable, .fixedReader,
		.handheld, .rateWant, .frameSel, .inByte, .inValid, .inReady, .chipAnswer,
		.chipError, .chipBlockCap, .fieldOn, .txBit, .txActive, .txKind, .linkRate,
		.curRate, .frameMax, .useEcc, .cardFound, .deadlineMiss, .errCnt);
	rpc_chip_model chip (.linkClk, .fieldOn, .txActive, .txKind, .typeB, .errMode,
		.capMode, .chipAnswer, .chipError, .chipBlockCap);

	////////////////////////////////////////////////////////////////////////////
	// log the kind of every byte as it starts on the link
	always @(posedge linkClk) begin
		wasAct <= txActive;
		if (txActive && !wasAct)
			kinds.push_back(txKind);
		// serial bits trail txActive by one cycle, so collect while its old level was high
		if (wasAct)
			rxSh <= {rxSh[6:0], txBit};
		if (wasAct && !txActive)
			bytes.push_back({rxSh[6:0], txBit});
	end
	// hang guard, well above the few thousand cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			results();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// next logged byte kind and the sys_clk cycles waited for it
	task automatic getk(output rpc_cmd_kind_t k, output int w);
		w = 0;
		while (kinds.size() == 0 && w < 3000) begin
			@(posedge sys_clk);
			w++;
		end
		k = (kinds.size() != 0) ? kinds.pop_front() : CMD_NONE;
	endtask : getk
	// bounded wait for fieldOn (sel 0), cardFound (1) or chipAnswer (2)
	task automatic waitFor(input int sel, input logic v, output int w);
		w = 0;
		while ((sel == 0 ? fieldOn : sel == 1 ? cardFound : chipAnswer) !== v && w < 3000) begin
			@(negedge sys_clk);
			w++;
		end
	endtask : waitFor

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		repeat (4) @(negedge sys_clk);
		chk(fieldOn, 0);
		chk(curRate, R106);
		chk(frameMax, 13'h0100);
		chk(inReady, 0);
		@(posedge sys_clk);
		nrst <= 1;
		repeat (2) @(negedge sys_clk);
		chk(inReady, 1);
	endtask : t_reset
	// fixed reader, type B chip without block transport
	task automatic t_poll();
		rpc_cmd_kind_t k;
		int            w;
		@(posedge sys_clk);
		{typeB, capMode, fixedReader, pollEnable} <= 4'hB;
		getk(k, w);
		chk(k, CMD_POLLA);
		chk(w >= LEAD + 1, 1);
		getk(k, w);
		chk(k, CMD_POLLB);
		waitFor(0, 0, w);
		chk(w < 1000, 1);
		chk(bytes.pop_front(), 8'h5A);
		chk(bytes.pop_front(), 8'hA5);
		chk(cardFound, 0);
		waitFor(0, 1, w);
		kinds.delete();
		getk(k, w);
		chk(k, CMD_POLLA);
		chk(w >= LEAD, 1);
		chk(deadlineMiss, 0);
		pollEnable <= 0;
	endtask : t_poll
	// fill while idle, then a session at 848 kbit/s with 4 kbyte frames
	task automatic t_session();
		rpc_cmd_kind_t k;
		int            w;
		@(posedge sys_clk);
		{typeB, capMode, fixedReader} <= 3'h2;
		frameSel <= 2'h3;
		rateWant <= R848;
		w = 0;
		for (int i = 0; i < 6; i++) begin
			inByte <= {8'(i), i == 3};
			inValid <= 1;
			@(posedge sys_clk);
			w += inReady;
		end
		inValid <= 0;
		chk(w, 4);
		pollEnable <= 1;
		waitFor(1, 1, w);
		chk(frameMax, 13'h1000);
		chk(useEcc, 1);
		chk(curRate, R848);
		kinds.delete();
		for (int i = 0; i < 4; i++) begin
			getk(k, w);
			chk(k, CMD_DATA);
		end
		getk(k, w);
		chk(k, CMD_FEND);
		chk(linkRate, R848);
		waitFor(2, 1, w);
		@(posedge sys_clk);
		errMode <= 1;
		inByte <= {8'h77, 1'b1};
		inValid <= 1;
		@(posedge sys_clk);
		chk(inReady, 1);
		inValid <= 0;
		getk(k, w);
		chk(k, CMD_DATA);
		getk(k, w);
		chk(k, CMD_FEND);
		getk(k, w);
		chk(k, CMD_NAK);
		@(negedge sys_clk);
		chk(errCnt, 1);
		getk(k, w);
		chk(k, CMD_NAK);
		waitFor(1, 0, w);
		chk(w < 1000, 1);
		@(posedge sys_clk);
		pollEnable <= 0;
		errMode <= 0;
	endtask : t_session
	// three frames that fail once and recover on the NAK force the fallback
	task automatic t_fallback();
		int w;
		@(posedge sys_clk);
		pollEnable <= 1;
		waitFor(1, 1, w);
		for (int i = 0; i < 3; i++) begin
			waitFor(2, 0, w);
			@(posedge sys_clk);
			errMode <= 1;
			inByte <= {8'(i), 1'b1};
			inValid <= 1;
			@(posedge sys_clk);
			inValid <= 0;
			waitFor(2, 1, w);
			@(posedge sys_clk);
			errMode <= 0;
			waitFor(2, 0, w);
			waitFor(2, 1, w);
		end
		repeat (4) @(negedge sys_clk);
		chk(curRate, R106);
		chk(frameMax, 13'h0100);
		chk(errCnt, 0);
		chk(useEcc, 0);
		chk(linkRate, R106);
		chk(cardFound, 1);
		@(posedge sys_clk);
		pollEnable <= 0;
	endtask : t_fallback
	// handheld reader asking for 4 kbyte frames at 424 kbit/s
	task automatic t_handheld();
		int w;
		repeat (2) @(posedge sys_clk);
		handheld <= 1;
		rateWant <= R424;
		pollEnable <= 1;
		waitFor(1, 1, w);
		chk(frameMax, 13'h0100);
		chk(useEcc, 0);
		chk(curRate, R424);
		repeat (10) @(negedge sys_clk);
		chk(linkRate, R424);
	endtask : t_handheld

	task automatic results();
		$display("checked %0d, miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	initial begin
		t_reset();
		t_poll();
		t_session();
		t_fallback();
		t_handheld();
		results();
	end
endmodule : tb_rpc_reader
